// File: dv/lvds_capture.sv
`timescale 1ns/1ps
`default_nettype none
module lvds_capture (
	input  wire logic        link_clk,
	input  wire logic        dclk,
	input  wire logic [11:0] pri,
	input  wire logic [11:0] dly,
	input  wire logic        ovr,
	output logic      [11:0] got_pri,
	output logic      [11:0] got_dly,
	output logic             got_ovr,
	output int               frames
);
	logic last_dclk = 1'b0;
	int   count     = 0;
	assign frames = count;
	// ddr data clock: each edge marks a new frame, words settled one link edge earlier
	always @(posedge link_clk) begin
		last_dclk <= dclk;
		if (dclk !== last_dclk) begin
			got_pri <= pri;
			got_dly <= dly;
			got_ovr <= ovr;
			count   <= count + 1;
		end
	end
endmodule
`default_nettype wire

// File: dv/tb_conv_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_conv_output_ctrl;
	// long enough to hold a full low and high request inside one calibration
	localparam int unsigned CAL_N = 3000;
	logic        sys_clk, rst, link_clk, cal_pin, ext_mode, des_pin, low_rate, demux, cfg_des, cfg_twos;
	logic [11:0] rate;
	logic [13:0] raw_a, raw_b;
	logic        cal_busy, rate_ok, des_active, ovr_a, ovr_b, dclk_a, dclk_b, cap_oa, cap_ob;
	logic [11:0] pri_a, dly_a, pri_b, dly_b, cap_pa, cap_da, cap_pb, cap_db;
	int          frames_a, frames_b, err_total, n_checks;
	int          vals[8] = '{-8192, -1, 0, 1, 2048, 4095, 4096, 8191};
	int          edges[6] = '{199, 499, 801, 1601, 3200, 3201};

	conv_output_ctrl #(.CAL_CYCLES(CAL_N)) dut (
		.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .cal_request_pin(cal_pin),
		.extended_serial_control_mode(ext_mode), .des_pin(des_pin), .low_rate_power_save_mode(low_rate),
		.demux_pin(demux), .cfg_des(cfg_des), .cfg_twos_complement(cfg_twos), .sample_rate_msps(rate),
		.first_channel_analog_input(raw_a), .second_channel_analog_input(raw_b), .cal_busy(cal_busy),
		.rate_in_range(rate_ok), .des_active(des_active), .first_channel_out_of_range(ovr_a),
		.second_channel_out_of_range(ovr_b), .first_channel_primary_bus(pri_a),
		.first_channel_delayed_bus(dly_a), .second_channel_primary_bus(pri_b),
		.second_channel_delayed_bus(dly_b), .first_channel_data_clock(dclk_a),
		.second_channel_data_clock(dclk_b));
	lvds_capture cap_a (.link_clk(link_clk), .dclk(dclk_a), .pri(pri_a), .dly(dly_a), .ovr(ovr_a),
		.got_pri(cap_pa), .got_dly(cap_da), .got_ovr(cap_oa), .frames(frames_a));
	lvds_capture cap_b (.link_clk(link_clk), .dclk(dclk_b), .pri(pri_b), .dly(dly_b), .ovr(ovr_b),
		.got_pri(cap_pb), .got_dly(cap_db), .got_ovr(cap_ob), .frames(frames_b));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// odd offset keeps the link phase unrelated to the sample clock
	initial begin
		link_clk = 1'b0;
		#3.7;
		forever #7.5 link_clk = ~link_clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [11:0] model_word(input int raw, input bit twos);
		int v;
		v = (raw < 0) ? 0 : (raw > 4095) ? 4095 : raw;
		model_word = 12'(v) ^ (twos ? 12'h800 : 12'h000);
	endfunction

	// inputs held steady so dropped frames cannot hide a wrong word
	task automatic apply(input int va, input int vb);
		int f0;
		int f1;
		raw_a = 14'(va);
		raw_b = 14'(vb);
		step(20);
		f0 = frames_a;
		f1 = frames_b;
		step(20);
		chk("frames_a", 12'h001, 12'(frames_a > f0));
		chk("frames_b", 12'h001, 12'(frames_b > f1));
		chk("pri_a", model_word(va, cfg_twos), cap_pa);
		chk("pri_b", model_word(vb, cfg_twos), cap_pb);
		chk("ovr_a", 12'(va < 0 || va > 4095), 12'(cap_oa));
		chk("ovr_b", 12'(vb < 0 || vb > 4095), 12'(cap_ob));
		if (demux) begin
			chk("dly_a", model_word(va, cfg_twos), cap_da);
			chk("dly_b", model_word(vb, cfg_twos), cap_db);
		end
	endtask

	task automatic rate_case(input bit ext, input bit d, input bit lo, input int r);
		int lo_lim, hi_lim;
		ext_mode = ext;
		des_pin  = ext ? !d : d;
		cfg_des  = ext ? d : !d;
		low_rate = lo;
		rate     = 12'(r);
		step(6);
		lo_lim = d ? 500 : 200;
		hi_lim = d ? (lo ? 1600 : 3200) : (lo ? 800 : 1600);
		chk("des_active", 12'(d), 12'(des_active));
		chk("rate_in_range", 12'(r >= lo_lim && r <= hi_lim), 12'(rate_ok));
	endtask

	task automatic cal_seq(input int low_n, input bit want);
		int n;
		cal_pin = 1'b0;
		step(low_n);
		cal_pin = 1'b1;
		n = 0;
		while (cal_busy !== 1'b1 && n < 1400) begin
			step(1);
			n++;
		end
		chk("cal started", 12'(want), 12'(cal_busy === 1'b1));
		if (want && cal_busy !== 1'b1)
			print_verdict();
		if (want) begin
			chk("cal high wait", 12'h001, 12'(n >= 1280));
			cal_pin = 1'b0;
			n = 0;
			// a full request during the run must leave no trace
			while (cal_busy === 1'b1 && n < CAL_N + 100) begin
				cal_pin = (n >= 1300);
				step(1);
				n++;
			end
			chk("cal length", 12'(CAL_N), 12'(n));
			cal_pin = 1'b1;
			step(1400);
			chk("cal ignored", 12'h000, 12'(cal_busy));
		end
	endtask

	initial begin
		rst = 1'b1;
		cal_pin = 1'b1;
		ext_mode = 1'b0;
		des_pin = 1'b0;
		low_rate = 1'b0;
		demux = 1'b0;
		cfg_des = 1'b0;
		cfg_twos = 1'b0;
		rate = 12'h3E8;
		raw_a = 14'h0000;
		raw_b = 14'h0000;
		err_total = 0;
		n_checks = 0;
		void'($urandom(59));
		step(6);
		rst = 1'b0;
		step(4);
		for (int dm = 0; dm < 2; dm++) begin
			demux = dm[0];
			foreach (vals[i])
				apply(vals[i], vals[7 - i]);
			repeat (3)
				apply(int'($signed(14'($urandom))), int'($signed(14'($urandom))));
			$display("test clamp demux=%0d done", dm);
		end
		ext_mode = 1'b1;
		cfg_twos = 1'b1;
		repeat (4)
			apply($urandom_range(4095), $urandom_range(4095));
		cfg_twos = 1'b0;
		$display("test format done");
		for (int m = 0; m < 8; m++) begin
			foreach (vals[i])
				rate_case(m[2], m[1], m[0], (i < 4) ? (200 + 300 * i) : (800 + 400 * (i - 4)) + i % 2);
			rate_case(m[2], m[1], m[0], $urandom_range(4095));
			foreach (edges[j])
				rate_case(m[2], m[1], m[0], edges[j]);
		end
		rate_case(1'b0, 1'b0, 1'b0, 1000);
		$display("test rate done");
		cal_seq(100, 1'b0);
		cal_seq(1300, 1'b1);
		$display("test calibration done");
		print_verdict();
	end

	// guard against a hang anywhere in the sequence
	initial begin
		#300000;
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire

// File: rtl/channel_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module channel_clamp (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [13:0] raw,
	output logic      [11:0] code,
	output logic             out_of_range
);
	typedef struct packed {
		logic [11:0] code;
		logic        ovr;
	} clamp_s;
	clamp_s q;
	clamp_s next_q;
	logic   below;
	logic   above;

	assign below = raw[13];
	assign above = !raw[13] && (raw > conv_ctrl_pkg::RAW_FULL_SCALE);

	always_comb begin
		next_q = q;
		if (below) begin
			next_q.code = conv_ctrl_pkg::CODE_ZERO;
		end else if (above) begin
			next_q.code = conv_ctrl_pkg::CODE_ONES;
		end else begin
			next_q.code = raw[11:0];
		end
		next_q.ovr = below || above;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign code         = q.code;
	assign out_of_range = q.ovr;

	chk_clamp_low: assert property (@(posedge sys_clk) disable iff (rst)
		$signed(raw) < 0 |=> code == conv_ctrl_pkg::CODE_ZERO && out_of_range)
		else $error("negative input not clamped to zero");
	chk_clamp_high: assert property (@(posedge sys_clk) disable iff (rst)
		$signed(raw) > $signed(conv_ctrl_pkg::RAW_FULL_SCALE) |=> code == conv_ctrl_pkg::CODE_ONES)
		else $error("over-scale input not clamped to ones");
	chk_code_pass: assert property (@(posedge sys_clk) disable iff (rst)
		!raw[13] && raw <= conv_ctrl_pkg::RAW_FULL_SCALE |=> code == $past(raw[11:0]) && !out_of_range)
		else $error("in-range sample altered or flagged");
endmodule
`default_nettype wire

// File: rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;
	localparam int          WORD_W            = 12;
	localparam int          RAW_W             = 14;
	localparam int          RATE_W            = 12;
	localparam logic [11:0] CODE_ZERO         = 12'h000;
	localparam logic [11:0] CODE_ONES         = 12'hFFF;
	localparam logic [11:0] FMT_SIGN_MASK     = 12'h800;
	localparam logic [13:0] RAW_FULL_SCALE    = 14'h0FFF;
	localparam logic [31:0] CAL_LOW_MIN       = 32'h00000500;
	localparam logic [31:0] CAL_HIGH_MIN      = 32'h00000500;
	localparam int unsigned CAL_CYCLES_DEFAULT = 41000000;
	localparam logic [11:0] RATE_DUAL_MIN     = 12'h0C8;
	localparam logic [11:0] RATE_DUAL_MAX     = 12'h640;
	localparam logic [11:0] RATE_DUAL_LOW_MAX = 12'h320;
	localparam logic [11:0] RATE_DES_MIN      = 12'h1F4;
	localparam logic [11:0] RATE_DES_MAX      = 12'hC80;
	localparam logic [11:0] RATE_DES_LOW_MAX  = 12'h640;
	localparam int          PIN_W             = 5;
	typedef enum logic [3:0] {
		CAL_WAIT_LOW = 4'h1,
		CAL_LOW      = 4'h2,
		CAL_HIGH     = 4'h4,
		CAL_RUN      = 4'h8
	} cal_state_e;
endpackage

// File: rtl/conv_output_ctrl.sv
// What this block does
// - each channel yields a 12-bit word
// - under negative full scale gives zeros, or 800h in two's complement
// - over positive full scale gives ones, or 7FFh in two's complement
// - clamping raises that channel's out-of-range flag
// - dual mode sample rate 200 to 1600
// - interleaved mode rate 500 to 3200
// - low-rate mode halves both upper rate limits
// - pin mode takes options from pins
// - serial mode adds serially programmed options
// - per-channel demux feeds two output buses
// - bus word rate full or half
// - identical channels, own data clocks, one clock
`timescale 1ns/1ps
`default_nettype none
module conv_output_ctrl #(
	parameter int unsigned CAL_CYCLES = conv_ctrl_pkg::CAL_CYCLES_DEFAULT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        link_clk,
	input  wire logic        cal_request_pin,
	input  wire logic        extended_serial_control_mode,
	input  wire logic        des_pin,
	input  wire logic        low_rate_power_save_mode,
	input  wire logic        demux_pin,
	input  wire logic        cfg_des,
	input  wire logic        cfg_twos_complement,
	input  wire logic [11:0] sample_rate_msps,
	input  wire logic [13:0] first_channel_analog_input,
	input  wire logic [13:0] second_channel_analog_input,
	output logic             cal_busy,
	output logic             rate_in_range,
	output logic             des_active,
	output logic             first_channel_out_of_range,
	output logic             second_channel_out_of_range,
	output logic [11:0]      first_channel_primary_bus,
	output logic [11:0]      first_channel_delayed_bus,
	output logic [11:0]      second_channel_primary_bus,
	output logic [11:0]      second_channel_delayed_bus,
	output logic             first_channel_data_clock,
	output logic             second_channel_data_clock
);
	typedef struct packed {
		conv_ctrl_pkg::cal_state_e cal_state;
		logic [31:0]               cal_cnt;
		logic                      des;
		logic                      demux;
		logic                      low_rate;
		logic                      twos;
		logic                      rate_ok;
		logic                      phase;
		logic                      req;
		logic [11:0]               a1;
		logic [11:0]               b1;
		logic                      oa;
		logic                      ob;
		logic [11:0]               h_a1;
		logic [11:0]               h_a2;
		logic [11:0]               h_b1;
		logic [11:0]               h_b2;
		logic                      h_oa;
		logic                      h_ob;
	} core_s;

	typedef struct packed {
		logic        req_seen;
		logic [11:0] a1;
		logic [11:0] a2;
		logic [11:0] b1;
		logic [11:0] b2;
		logic        oa;
		logic        ob;
		logic        dclk1;
		logic        dclk2;
	} link_s;

	localparam logic [31:0] CAL_LAST = 32'(CAL_CYCLES - 1);

	core_s       q;
	core_s       next_q;
	link_s       lq;
	link_s       next_lq;
	logic [4:0]  pins_s;
	logic        cal_s;
	logic        ext_s;
	logic        des_s;
	logic        low_rate_s;
	logic        demux_s;
	logic [11:0] code [2];
	logic [1:0]  ovr;
	logic [11:0] w0;
	logic [11:0] w1;
	logic [11:0] lo;
	logic [11:0] hi;
	logic        frame_done;
	logic        idle;
	logic        ack_s;
	logic        req_l;
	logic        rst_l;

	// pins come from outside the clock domain
	level_sync #(.WIDTH(conv_ctrl_pkg::PIN_W)) u_pin_sync (
		.clk      (sys_clk),
		.async_in ({cal_request_pin, extended_serial_control_mode, des_pin,
		            low_rate_power_save_mode, demux_pin}),
		.sync_out (pins_s)
	);
	assign {cal_s, ext_s, des_s, low_rate_s, demux_s} = pins_s;

	level_sync #(.WIDTH(1)) u_ack_sync (
		.clk      (sys_clk),
		.async_in (lq.req_seen),
		.sync_out (ack_s)
	);

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			channel_clamp u_clamp (
				.sys_clk      (sys_clk),
				.rst          (rst),
				.raw          (ch == 0 ? first_channel_analog_input : second_channel_analog_input),
				.code         (code[ch]),
				.out_of_range (ovr[ch])
			);
		end
	endgenerate

	assign idle       = (ack_s == q.req);
	assign frame_done = !q.demux || q.phase;
	assign w0         = code[0] ^ (q.twos ? conv_ctrl_pkg::FMT_SIGN_MASK : conv_ctrl_pkg::CODE_ZERO);
	assign w1         = code[1] ^ (q.twos ? conv_ctrl_pkg::FMT_SIGN_MASK : conv_ctrl_pkg::CODE_ZERO);

	always_comb begin
		next_q = q;
		// extended mode moves interleave and format to serial control
		next_q.des   = ext_s ? cfg_des : des_s;
		next_q.twos  = ext_s && cfg_twos_complement;
		next_q.demux = demux_s;
		next_q.low_rate = low_rate_s;

		lo = q.des ? conv_ctrl_pkg::RATE_DES_MIN : conv_ctrl_pkg::RATE_DUAL_MIN;
		if (q.des) begin
			hi = q.low_rate ? conv_ctrl_pkg::RATE_DES_LOW_MAX : conv_ctrl_pkg::RATE_DES_MAX;
		end else begin
			hi = q.low_rate ? conv_ctrl_pkg::RATE_DUAL_LOW_MAX : conv_ctrl_pkg::RATE_DUAL_MAX;
		end
		next_q.rate_ok = (sample_rate_msps >= lo) && (sample_rate_msps <= hi);

		case (q.cal_state)
			conv_ctrl_pkg::CAL_WAIT_LOW: begin
				if (!cal_s) begin
					next_q.cal_state = conv_ctrl_pkg::CAL_LOW;
					next_q.cal_cnt   = 32'd1;
				end
			end
			conv_ctrl_pkg::CAL_LOW: begin
				// a low phase that is too short is simply forgotten
				if (cal_s) begin
					next_q.cal_state = (q.cal_cnt >= conv_ctrl_pkg::CAL_LOW_MIN) ?
						conv_ctrl_pkg::CAL_HIGH : conv_ctrl_pkg::CAL_WAIT_LOW;
					next_q.cal_cnt   = 32'd1;
				end else if (q.cal_cnt < conv_ctrl_pkg::CAL_LOW_MIN) begin
					next_q.cal_cnt = q.cal_cnt + 32'd1;
				end
			end
			conv_ctrl_pkg::CAL_HIGH: begin
				if (!cal_s) begin
					next_q.cal_state = conv_ctrl_pkg::CAL_LOW;
					next_q.cal_cnt   = 32'd1;
				end else if (q.cal_cnt >= conv_ctrl_pkg::CAL_HIGH_MIN) begin
					next_q.cal_state = conv_ctrl_pkg::CAL_RUN;
					next_q.cal_cnt   = 32'd0;
				end else begin
					next_q.cal_cnt = q.cal_cnt + 32'd1;
				end
			end
			conv_ctrl_pkg::CAL_RUN: begin
				// the pin is not looked at here, so requests are dropped
				if (q.cal_cnt >= CAL_LAST) begin
					next_q.cal_state = conv_ctrl_pkg::CAL_WAIT_LOW;
					next_q.cal_cnt   = 32'd0;
				end else begin
					next_q.cal_cnt = q.cal_cnt + 32'd1;
				end
			end
			default: begin
				next_q.cal_state = conv_ctrl_pkg::CAL_WAIT_LOW;
				next_q.cal_cnt   = 32'd0;
			end
		endcase

		// demux gathers two samples per channel, one per bus, before a frame is offered
		next_q.phase = q.demux && !q.phase;
		if (!q.phase) begin
			next_q.a1 = w0;
			next_q.b1 = w1;
			next_q.oa = ovr[0];
			next_q.ob = ovr[1];
		end
		// frames that arrive while the link is busy are dropped
		if (frame_done && idle) begin
			next_q.req = !q.req;
			if (q.demux) begin
				next_q.h_a1 = q.a1;
				next_q.h_a2 = w0;
				next_q.h_b1 = q.b1;
				next_q.h_b2 = w1;
				next_q.h_oa = q.oa || ovr[0];
				next_q.h_ob = q.ob || ovr[1];
			end else begin
				next_q.h_a1 = w0;
				next_q.h_b1 = w1;
				next_q.h_oa = ovr[0];
				next_q.h_ob = ovr[1];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q           <= '0;
			q.cal_state <= conv_ctrl_pkg::CAL_WAIT_LOW;
		end else begin
			q <= next_q;
		end
	end

	assign cal_busy      = (q.cal_state == conv_ctrl_pkg::CAL_RUN);
	assign rate_in_range = q.rate_ok;
	assign des_active    = q.des;

	// link side: hold words stay stable while a request is pending
	level_sync #(.WIDTH(2)) u_link_sync (
		.clk      (link_clk),
		.async_in ({rst, q.req}),
		.sync_out ({rst_l, req_l})
	);

	always_comb begin
		next_lq = lq;
		if (req_l != lq.req_seen) begin
			next_lq.req_seen = req_l;
			next_lq.a1       = q.h_a1;
			next_lq.a2       = q.h_a2;
			next_lq.b1       = q.h_b1;
			next_lq.b2       = q.h_b2;
			next_lq.oa       = q.h_oa;
			next_lq.ob       = q.h_ob;
			next_lq.dclk1    = !lq.dclk1;
			next_lq.dclk2    = !lq.dclk2;
		end
	end

	always_ff @(posedge link_clk) begin
		if (rst_l) begin
			lq <= '0;
		end else begin
			lq <= next_lq;
		end
	end

	assign first_channel_primary_bus   = lq.a1;
	assign first_channel_delayed_bus   = lq.a2;
	assign second_channel_primary_bus  = lq.b1;
	assign second_channel_delayed_bus  = lq.b2;
	assign first_channel_out_of_range  = lq.oa;
	assign second_channel_out_of_range = lq.ob;
	assign first_channel_data_clock    = lq.dclk1;
	assign second_channel_data_clock   = lq.dclk2;

	sequence cal_low_done;
		q.cal_state == conv_ctrl_pkg::CAL_LOW && q.cal_cnt >= conv_ctrl_pkg::CAL_LOW_MIN;
	endsequence
	sequence cal_high_seen;
		q.cal_state == conv_ctrl_pkg::CAL_HIGH;
	endsequence

	chk_cal_low_min: assert property (@(posedge sys_clk) disable iff (rst)
		q.cal_state == conv_ctrl_pkg::CAL_LOW ##1 cal_high_seen |->
		$past(q.cal_cnt, 1) >= conv_ctrl_pkg::CAL_LOW_MIN)
		else $error("high phase entered after short low");
	chk_cal_start: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(cal_busy) |-> $past(q.cal_state) == conv_ctrl_pkg::CAL_HIGH
		&& $past(q.cal_cnt) >= conv_ctrl_pkg::CAL_HIGH_MIN)
		else $error("calibration started without high phase");
	chk_cal_busy_hold: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(cal_busy) |-> cal_busy[*8])
		else $error("busy dropped early");
	chk_cal_ignore: assert property (@(posedge sys_clk) disable iff (rst)
		cal_busy && q.cal_cnt < CAL_LAST |=> cal_busy && q.cal_cnt == $past(q.cal_cnt) + 32'd1)
		else $error("calibration disturbed while busy");
	chk_rate_dual: assert property (@(posedge sys_clk) disable iff (rst)
		!q.des && q.low_rate && $stable(q.des)
		&& sample_rate_msps == conv_ctrl_pkg::RATE_DUAL_LOW_MAX + 12'h001 |=> !rate_in_range)
		else $error("low-rate dual limit not applied");
	chk_rate_des: assert property (@(posedge sys_clk) disable iff (rst)
		q.des && !q.low_rate && $stable(q.low_rate)
		&& sample_rate_msps == conv_ctrl_pkg::RATE_DES_MAX |=> rate_in_range)
		else $error("interleaved top rate refused");
	chk_demux_half: assert property (@(posedge sys_clk) disable iff (rst)
		q.demux && $stable(q.demux) && q.req != $past(q.req) |=> q.req == $past(q.req))
		else $error("demux frames offered on consecutive cycles");
	chk_dclk_follow: assert property (@(posedge link_clk) disable iff (rst_l)
		req_l != lq.req_seen |=> first_channel_data_clock != $past(first_channel_data_clock)
		&& second_channel_data_clock != $past(second_channel_data_clock))
		else $error("data clock did not mark new words");

	sequence link_pending;
		q.req != ack_s;
	endsequence

	// the link side may copy the held words at any of its edges until the ack returns
	chk_hold_stable: assert property (@(posedge sys_clk) disable iff (rst)
		link_pending |=> $stable(q.h_a1) && $stable(q.h_a2) && $stable(q.h_b1) && $stable(q.h_b2))
		else $error("held words changed while link busy");
	chk_demux_pair: assert property (@(posedge sys_clk) disable iff (rst)
		q.demux && q.phase && idle |=> q.h_a1 == $past(q.a1) && q.h_a2 == $past(w0))
		else $error("demux pair not formed from both samples");
	chk_link_capture: assert property (@(posedge link_clk) disable iff (rst_l)
		req_l != lq.req_seen |=> first_channel_primary_bus == $past(q.h_a1)
		&& second_channel_primary_bus == $past(q.h_b1))
		else $error("link bus does not carry the held words");
	chk_link_ovr: assert property (@(posedge link_clk) disable iff (rst_l)
		req_l != lq.req_seen |=> first_channel_out_of_range == $past(q.h_oa)
		&& second_channel_out_of_range == $past(q.h_ob))
		else $error("range flag lost on the link");
	chk_rate_dual_top: assert property (@(posedge sys_clk) disable iff (rst)
		!q.des && !q.low_rate && sample_rate_msps == conv_ctrl_pkg::RATE_DUAL_MAX |=> rate_in_range)
		else $error("dual top rate refused");
	chk_rate_floor: assert property (@(posedge sys_clk) disable iff (rst)
		sample_rate_msps < conv_ctrl_pkg::RATE_DUAL_MIN |=> !rate_in_range)
		else $error("rate below floor accepted");
	chk_rate_des_low: assert property (@(posedge sys_clk) disable iff (rst)
		q.des && q.low_rate && sample_rate_msps > conv_ctrl_pkg::RATE_DES_LOW_MAX |=> !rate_in_range)
		else $error("low-rate interleaved limit not applied");
	// pin mode has no format choice, so offset binary only
	chk_pin_format: assert property (@(posedge sys_clk) disable iff (rst)
		!ext_s |=> !q.twos)
		else $error("format changed in pin mode");
	chk_pin_des: assert property (@(posedge sys_clk) disable iff (rst)
		!ext_s |=> des_active == $past(des_s))
		else $error("pin interleave select not followed");
	chk_serial_des: assert property (@(posedge sys_clk) disable iff (rst)
		ext_s |=> des_active == $past(cfg_des))
		else $error("serial interleave select not followed");
endmodule
`default_nettype wire

// File: rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;
	sync_s q;
	sync_s next_q;

	// no reset: the first stage must feed only the second
	always_comb begin
		next_q.meta   = async_in;
		next_q.stable = q.meta;
	end

	always_ff @(posedge clk) begin
		q <= next_q;
	end

	assign sync_out = q.stable;
endmodule
`default_nettype wire

// File: rtl/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
